// file: design/pwct_pkg.sv
package pwct_pkg;

	// register word addresses on the plain register port
	localparam logic [3:0] PWCT_ADDR_MODE    = 4'h0;
	localparam logic [3:0] PWCT_ADDR_CTRL    = 4'h1;
	localparam logic [3:0] PWCT_ADDR_STATUS  = 4'h2;
	localparam logic [3:0] PWCT_ADDR_IRQ_STS = 4'h3;
	localparam logic [3:0] PWCT_ADDR_IRQ_MSK = 4'h4;
	localparam logic [3:0] PWCT_ADDR_CAP_A   = 4'h5;
	localparam logic [3:0] PWCT_ADDR_CAP_B   = 4'h6;
	localparam logic [3:0] PWCT_ADDR_COUNT   = 4'h7;

	// mode field code that selects pulse width measurement
	localparam logic [2:0] PWCT_MODE_PWM = 3'h6;

	// control register bit positions
	localparam int PWCT_CTRL_RUN = 0;
	localparam int PWCT_CTRL_OVE = 1;

	// status register bit positions (cleared on read)
	localparam int PWCT_ST_CAPA = 0;
	localparam int PWCT_ST_CAPB = 1;
	localparam int PWCT_ST_OVF  = 2;

	// interrupt status / mask bit positions (status is write one to clear)
	localparam int PWCT_IRQ_START = 0;
	localparam int PWCT_IRQ_CAPB  = 1;
	localparam int PWCT_IRQ_CAPA  = 2;
	localparam int PWCT_IRQ_OVF   = 3;

	// reset values
	localparam logic [15:0] PWCT_CNT_RST  = 16'h0000;
	localparam logic [7:0]  PWCT_MODE_RST = 8'h00;
	localparam logic [3:0]  PWCT_MASK_RST = 4'hF;

	// timer mode register layout, msb first
	typedef struct packed {
		logic       style_single;   // capture_style_sel
		logic       falling_start;  // edge_polarity_sel
		logic [2:0] clk_sel;        // source_clock_sel
		logic [2:0] mode;           // mode_select_field
	} pwct_mode_t;

	// register port request bundle
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [15:0] wdata;
	} pwct_req_t;

	// measurement sequence, gray coded along the usual path
	typedef enum logic [1:0] {
		PWCT_ST_IDLE  = 2'b00,
		PWCT_ST_ARM   = 2'b01,
		PWCT_ST_MEAS  = 2'b11,
		PWCT_ST_AFTER = 2'b10
	} pwct_state_t;

endpackage

// file: design/pwct_timer.sv
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - start edge raises irq, then counting begins
// - opposite edge captures into B, flags, irq
// - double style: next start captures A, clears
// - single style: stop and clear, resume later
// - overflow during measurement sets overflow flag
// - overflow irq only when enable bit set
// - status read clears all three flags
// - clearing run stops and zeroes counter
// - opposite edge first is ignored entirely
// - mode code 110 selects; clock field separate
// - polarity bit picks rising or falling start
// - setting run zeroes both capture registers
// - mode and enable writes ignored while running
module pwct_timer
	import pwct_pkg::*;
#(
	parameter int CNT_W = 16,  // up counter width
	parameter int PRE_W = 7    // prescaler width, divides up to 2**7 at clock select 7
)(
	input  wire logic        clock_i,
	input  wire logic        rstn_i,
	input  wire logic [3:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic        capture_input_pin_i,
	output logic      [15:0] rdata_o,
	output logic             timer_event_irq_o
);

	// the register map and capture path are fixed at one 16-bit word
	if (CNT_W != 16) begin : g_chk_w
		$error("pwct_timer: CNT_W must be 16");
	end
	// the slowest source clock select needs all seven prescaler bits
	if (PRE_W < 7) begin : g_chk_p
		$error("pwct_timer: PRE_W must be at least 7");
	end

	// tick when the low sel bits of the prescaler are all ones
	function automatic logic tick_of(input logic [2:0] sel,
		input logic [PRE_W-1:0] pre);
		logic [PRE_W-1:0] m;
		m = PRE_W'((1 << sel) - 1);
		tick_of = ((pre & m) == m);
	endfunction

	// register port bundle
	pwct_req_t req;
	assign req = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

	// software visible state
	pwct_mode_t       mode_reg;      // timer_mode_reg
	logic             run_reg;       // run_bit
	logic             ove_reg;       // overflow_irq_enable
	logic [2:0]       status_reg;    // timer_status_reg flags
	logic [3:0]       irq_sts_reg;   // sticky interrupt causes
	logic [3:0]       irq_msk_reg;   // interrupt mask, 1 passes
	logic [15:0]      cap_a_reg;     // capture_reg_a
	logic [15:0]      cap_b_reg;     // capture_reg_b
	logic [15:0]      cnt_reg;       // up counter
	logic [PRE_W-1:0] pre_reg;       // source clock prescaler
	pwct_state_t      state_reg;     // measurement sequence
	pwct_state_t      state_next;
	logic [15:0]      rdata_reg;
	logic             irq_reg;

	// pin synchroniser; sync1 feeds only sync2
	logic pin_s1_reg;
	logic pin_s2_reg;
	logic pin_s3_reg;   // previous synced level, for edges

	// write and status read decode
	wire wr_mode = req.wr && req.addr == PWCT_ADDR_MODE;
	wire wr_ctrl = req.wr && req.addr == PWCT_ADDR_CTRL;
	wire wr_isc  = req.wr && req.addr == PWCT_ADDR_IRQ_STS;
	wire wr_msk  = req.wr && req.addr == PWCT_ADDR_IRQ_MSK;
	wire rd_st   = req.rd && req.addr == PWCT_ADDR_STATUS;

	// run bit transitions
	wire run_set = wr_ctrl && req.wdata[PWCT_CTRL_RUN] && !run_reg;
	wire run_clr = wr_ctrl && !req.wdata[PWCT_CTRL_RUN] && run_reg;

	// edge detection on the synchronised pin
	wire rise     = pin_s2_reg && !pin_s3_reg;
	wire fall     = !pin_s2_reg && pin_s3_reg;
	// falling start when polarity bit is 1, rising when 0
	wire start_e  = mode_reg.falling_start ? fall : rise;
	wire opp_e    = mode_reg.falling_start ? rise : fall;

	// only the pulse width code lets the sequence leave idle
	wire pwm_sel  = mode_reg.mode == PWCT_MODE_PWM;
	// a stop write acts at its own edge, so a read right behind it
	// already sees a zero counter and no late event slips through
	wire active   = run_reg && pwm_sel && !run_clr;

	// source clock tick from prescaler
	// select n gives one tick every 2**n system clocks
	wire tick     = tick_of(mode_reg.clk_sel, pre_reg);

	// counting happens in measure, and after opposite in double style
	wire counting = (state_reg == PWCT_ST_MEAS) ||
		(state_reg == PWCT_ST_AFTER && !mode_reg.style_single);

	// sequence events
	wire ev_start = active && start_e &&
		(state_reg == PWCT_ST_ARM || state_reg == PWCT_ST_AFTER);
	wire ev_capb  = active && opp_e &&
		state_reg == PWCT_ST_MEAS;
	wire ev_capa  = ev_start && state_reg == PWCT_ST_AFTER &&
		!mode_reg.style_single;
	wire cnt_max  = cnt_reg == 16'hFFFF;
	wire ev_ovf   = active && counting && tick && cnt_max &&
		!ev_capa && !ev_capb;

	// event vector for the interrupt status register
	wire [3:0] irq_set = {ev_ovf && ove_reg,
		ev_capa, ev_capb, ev_start};

	// next state of the measurement sequence
	always_comb begin
		state_next = state_reg;
		if (!active) begin
			state_next = PWCT_ST_IDLE;
		end else begin
			unique case (state_reg)
				PWCT_ST_IDLE: begin
					state_next = PWCT_ST_ARM;
				end
				// opposite edge here is simply ignored
				PWCT_ST_ARM: begin
					if (start_e) begin
						state_next = PWCT_ST_MEAS;
					end
				end
				PWCT_ST_MEAS: begin
					if (opp_e) begin
						state_next = PWCT_ST_AFTER;
					end
				end
				PWCT_ST_AFTER: begin
					if (start_e) begin
						state_next = PWCT_ST_MEAS;
					end
				end
			endcase
		end
	end

	// counter next value; wrap keeps the sequence untouched
	logic [15:0] cnt_next;
	always_comb begin
		cnt_next = cnt_reg;
		if (!active) begin
			cnt_next = PWCT_CNT_RST;
		end else if (ev_capa) begin
			cnt_next = PWCT_CNT_RST;
		end else if (ev_capb && mode_reg.style_single) begin
			cnt_next = PWCT_CNT_RST;
		end else if (state_reg == PWCT_ST_AFTER &&
			mode_reg.style_single) begin
			cnt_next = PWCT_CNT_RST;
		end else if (counting && tick) begin
			cnt_next = cnt_reg + 16'h0001;
		end
	end

	// status flags: a new event beats a clearing read; the read
	// data flop takes the old flags at the same edge they clear
	wire [2:0] st_set = {ev_ovf, ev_capb, ev_capa};
	wire [2:0] st_next = (status_reg & {3{!rd_st}}) | st_set;

	// interrupt causes: write one clears, set still wins
	wire [3:0] isc_next = (irq_sts_reg &
		~(wr_isc ? req.wdata[3:0] : 4'h0)) | irq_set;

	// read mux, unmapped addresses read as zero
	logic [15:0] rd_mux;
	always_comb begin
		unique case (req.addr)
			PWCT_ADDR_MODE:    rd_mux = {8'h00, mode_reg};
			PWCT_ADDR_CTRL:    rd_mux = {14'h0000, ove_reg, run_reg};
			PWCT_ADDR_STATUS:  rd_mux = {13'h0000, status_reg};
			PWCT_ADDR_IRQ_STS: rd_mux = {12'h000, irq_sts_reg};
			PWCT_ADDR_IRQ_MSK: rd_mux = {12'h000, irq_msk_reg};
			PWCT_ADDR_CAP_A:   rd_mux = cap_a_reg;
			PWCT_ADDR_CAP_B:   rd_mux = cap_b_reg;
			PWCT_ADDR_COUNT:   rd_mux = cnt_reg;
			default:           rd_mux = 16'h0000;
		endcase
	end

	// pin synchroniser and edge history
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			pin_s1_reg <= 1'b0;
			pin_s2_reg <= 1'b0;
			pin_s3_reg <= 1'b0;
		end else begin
			pin_s1_reg <= capture_input_pin_i;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
		end
	end

	// configuration: mode and enable locked while running so a live
	// measurement cannot change meaning under software
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			mode_reg <= pwct_mode_t'(PWCT_MODE_RST);
			run_reg  <= 1'b0;
			ove_reg  <= 1'b0;
		end else begin
			if (wr_mode && !run_reg) begin
				mode_reg <= pwct_mode_t'(req.wdata[7:0]);
			end
			if (wr_ctrl) begin
				run_reg <= req.wdata[PWCT_CTRL_RUN];
			end
			if (wr_ctrl && !run_reg) begin
				ove_reg <= req.wdata[PWCT_CTRL_OVE];
			end
		end
	end

	// mask register
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			irq_msk_reg <= PWCT_MASK_RST;
		end else if (wr_msk) begin
			irq_msk_reg <= req.wdata[3:0];
		end
	end

	// capture registers; cleared when the run bit goes high
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			cap_a_reg <= PWCT_CNT_RST;
			cap_b_reg <= PWCT_CNT_RST;
		end else if (run_set) begin
			cap_a_reg <= PWCT_CNT_RST;
			cap_b_reg <= PWCT_CNT_RST;
		end else begin
			if (ev_capa) begin
				cap_a_reg <= cnt_reg;
			end
			if (ev_capb) begin
				cap_b_reg <= cnt_reg;
			end
		end
	end

	// prescaler runs only while active, so the first tick
	// lands a fixed time after the run bit is set
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			pre_reg <= '0;
		end else if (!active) begin
			pre_reg <= '0;
		end else begin
			pre_reg <= pre_reg + PRE_W'(1);
		end
	end

	// counter, sequence and flags
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			cnt_reg     <= PWCT_CNT_RST;
			state_reg   <= PWCT_ST_IDLE;
			status_reg  <= 3'h0;
			irq_sts_reg <= 4'h0;
		end else begin
			cnt_reg     <= cnt_next;
			state_reg   <= state_next;
			status_reg  <= st_next;
			irq_sts_reg <= isc_next;
		end
	end

	// read data and interrupt line; both come from flops
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			rdata_reg <= 16'h0000;
			irq_reg   <= 1'b0;
		end else begin
			rdata_reg <= req.rd ? rd_mux : 16'h0000;
			irq_reg   <= |(irq_sts_reg & irq_msk_reg);
		end
	end

	assign rdata_o           = rdata_reg;
	assign timer_event_irq_o = irq_reg;

endmodule

`default_nettype wire

// file: dv/pwct_timer_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// watches register replies and the irq line at the timer's ports
module pwct_timer_monitor
	import pwct_pkg::*;
(
	input wire logic        clock_i,
	input wire logic        rstn_i,
	input wire logic [3:0]  addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic        capture_input_pin_i,
	input wire logic [15:0] rdata_o,
	input wire logic        timer_event_irq_o
);
	logic       run_q;  // run bit as last written
	logic       ove_q;  // enable bit as accepted
	logic [7:0] mode_q; // mode as accepted, locked while running
	wire        ctl_w = wr_i && addr_i == PWCT_ADDR_CTRL;
	wire        mod_w = wr_i && addr_i == PWCT_ADDR_MODE;
	wire        msk_w = wr_i && addr_i == PWCT_ADDR_IRQ_MSK;

	// shadow of the set-up registers; mode and enable writes while running are dropped
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			run_q  <= 1'b0;
			ove_q  <= 1'b0;
			mode_q <= 8'h00;
		end else begin
			if (ctl_w) run_q <= wdata_i[0];
			if (ctl_w && !run_q) ove_q <= wdata_i[1];
			if (mod_w && !run_q) mode_q <= wdata_i[7:0];
		end
	end

	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);

	AST_RD_IDLE: assert property (
		!rd_i |=> rdata_o == 16'h0000) else $error("stray read data");
	AST_IRQ_RST: assert property (
		$rose(rstn_i) |-> !timer_event_irq_o) else $error("irq after reset");
	AST_MASK_OFF: assert property (
		msk_w && wdata_i[3:0] == 4'h0 ##1 !msk_w |=> !timer_event_irq_o)
		else $error("masked irq still high");
	AST_CAP_INIT: assert property (
		ctl_w && wdata_i[0] && !run_q ##1 rd_i && addr_i == PWCT_ADDR_CAP_B
		|=> rdata_o == 16'h0000) else $error("capture not cleared at start");
	AST_CNT_STOP: assert property (
		rd_i && addr_i == PWCT_ADDR_COUNT && !run_q |=> rdata_o == 16'h0000)
		else $error("counter not zero while stopped");
	AST_MODE_LOCK: assert property (
		rd_i && addr_i == PWCT_ADDR_MODE |=> rdata_o == {8'h00, mode_q})
		else $error("mode changed while running");
	AST_CTRL_LOCK: assert property (
		rd_i && addr_i == PWCT_ADDR_CTRL |=> rdata_o[1:0] == {ove_q, run_q})
		else $error("enable changed while running");
	AST_UNMAPPED: assert property (
		rd_i && addr_i[3] |=> rdata_o == 16'h0000)
		else $error("unmapped read not zero");

	CVR_RUN: cover property (ctl_w && wdata_i[0] && !run_q);
	CVR_IRQ: cover property ($rose(timer_event_irq_o));
	CVR_PIN: cover property ($rose(capture_input_pin_i));
endmodule
`default_nettype wire

// file: dv/pwct_pulse_src.sv
`timescale 1ns/100ps
`default_nettype none
// external pulse source on the capture pin
module pwct_pulse_src (
	input  wire logic clock_i,
	output var  logic pin_o
);
	initial pin_o = 1'b0;
	// hold a level; under three clocks the synchroniser may miss it
	task automatic hold(input logic lvl, input int n);
		pin_o <= lvl;
		repeat (n < 3 ? 3 : n) @(posedge clock_i);
	endtask
endmodule
`default_nettype wire

// file: dv/test_pwct_timer.sv
`timescale 1ns/100ps
`default_nettype none
// self-checking bench for the pulse width capture timer
module test_pwct_timer;
	import pwct_pkg::*;
	logic        clock_i;
	logic        rstn_i;
	logic        wr_i;
	logic        rd_i;
	logic [3:0]  addr_i;
	logic [15:0] wdata_i;
	wire  [15:0] rdata;
	wire         irq;
	wire         pin;
	int          error_cnt = 0;
	int          cmp_count = 0;
	int          seed      = 32'h92a914c2;

	pwct_timer pwct_timer_i (
		.clock_i             (clock_i),
		.rstn_i              (rstn_i),
		.addr_i              (addr_i),
		.wdata_i             (wdata_i),
		.wr_i                (wr_i),
		.rd_i                (rd_i),
		.capture_input_pin_i (pin),
		.rdata_o             (rdata),
		.timer_event_irq_o   (irq)
	);
	pwct_pulse_src pwct_pulse_src_i (.clock_i(clock_i), .pin_o(pin));

	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end

	// one bus cycle; the next call may follow with no gap
	task automatic op(input logic w, r, input logic [3:0] a,
			input logic [15:0] d);
		wr_i    <= w;
		rd_i    <= r;
		addr_i  <= a;
		wdata_i <= d;
		@(posedge clock_i);
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		op(1'b1, 1'b0, a, d);
		op(1'b0, 1'b0, a, d);
	endtask
	// data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		op(1'b0, 1'b1, a, 16'h0000);
		rd_i <= 1'b0;
		@(negedge clock_i);
		d = rdata;
		@(posedge clock_i);
	endtask
	task automatic chk(input logic [15:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// edge sampling may put a tick count one either side of the ideal
	function automatic logic near(input logic [15:0] got, input int ex);
		logic [15:0] d;
		d = got - ex[15:0] + 16'h0001;
		return d <= 16'h0002;
	endfunction
	task automatic complete_run();
		$display("errors=%0d compares=%0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// one full measurement: ignored edge, width, period, flags, stop
	task automatic measure(input logic st, pl, input logic [2:0] sel,
			input int hi, lo);
		logic        a;
		logic        ov;
		logic [15:0] d;
		logic [15:0] md;
		a  = ~pl;
		ov = (hi >> sel) > 65535;
		md = {8'h00, st, pl, sel, PWCT_MODE_PWM};
		pwct_pulse_src_i.hold(a, 4);
		wr(PWCT_ADDR_MODE, md);
		op(1'b1, 1'b0, PWCT_ADDR_CTRL, 16'h0003);
		rd(PWCT_ADDR_CAP_B, d);
		chk(d, 16'h0000);
		wr(PWCT_ADDR_MODE, 16'h0000);
		rd(PWCT_ADDR_MODE, d);
		chk(d, md);
		pwct_pulse_src_i.hold(~a, 6);
		rd(PWCT_ADDR_IRQ_STS, d);
		chk(d, 16'h0000);
		pwct_pulse_src_i.hold(a, hi);
		pwct_pulse_src_i.hold(~a, 6);
		rd(PWCT_ADDR_CAP_B, d);
		chk(near(d, hi >> sel), 1'b1);
		if (st) begin
			rd(PWCT_ADDR_COUNT, d);
			chk(d, 16'h0000);
		end
		pwct_pulse_src_i.hold(~a, lo);
		pwct_pulse_src_i.hold(a, 6);
		rd(PWCT_ADDR_CAP_A, d);
		if (st) chk(d, 16'h0000);
		else chk(near(d, (hi + lo + 8) >> sel), 1'b1);
		rd(PWCT_ADDR_STATUS, d);
		chk(d[2:0], {ov, 1'b1, ~st});
		rd(PWCT_ADDR_STATUS, d);
		chk(d[2:0], 3'h0);
		rd(PWCT_ADDR_IRQ_STS, d);
		chk(d[3:0], {ov, ~st, 2'b11});
		chk(irq, 1'b1);
		wr(PWCT_ADDR_IRQ_MSK, 16'h0000);
		@(posedge clock_i);
		chk(irq, 1'b0);
		wr(PWCT_ADDR_IRQ_STS, 16'h000F);
		wr(PWCT_ADDR_IRQ_MSK, 16'h000F);
		@(posedge clock_i);
		chk(irq, 1'b0);
		op(1'b1, 1'b0, PWCT_ADDR_CTRL, 16'h0000);
		rd(PWCT_ADDR_COUNT, d);
		chk(d, 16'h0000);
	endtask

	initial begin
		logic [15:0] d;
		logic [31:0] r;
		rstn_i  = 1'b0;
		wr_i    = 1'b0;
		rd_i    = 1'b0;
		addr_i  = 4'h0;
		wdata_i = 16'h0000;
		repeat (10) @(posedge clock_i);
		rstn_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		rd(PWCT_ADDR_IRQ_MSK, d);
		chk(d, {12'h000, PWCT_MASK_RST});
		measure(1'b0, 1'b0, 3'h0, 3, 3);
		// a mode code other than pulse width keeps the block idle
		wr(PWCT_ADDR_MODE, 16'h0002);
		wr(PWCT_ADDR_CTRL, 16'h0003);
		pwct_pulse_src_i.hold(1'b1, 6);
		pwct_pulse_src_i.hold(1'b0, 6);
		rd(PWCT_ADDR_COUNT, d);
		chk(d, 16'h0000);
		rd(PWCT_ADDR_IRQ_STS, d);
		chk(d, 16'h0000);
		wr(PWCT_ADDR_CTRL, 16'h0000);
		// counter wraps in mid pulse
		measure(1'b1, 1'b1, 3'h0, 65540, 5);
		repeat (6) begin
			r = $random(seed);
			measure(r[0], r[1], {1'b0, r[3:2]}, 3 + r[9:4], 3 + r[15:10]);
		end
		// enable write while running was dropped, run clear was not
		rd(PWCT_ADDR_CTRL, d);
		chk(d[1:0], 2'b10);
		rd(4'h9, d);
		chk(d, 16'h0000);
		complete_run();
	end

	initial begin
		repeat (90000) @(posedge clock_i);
		error_cnt++;
		complete_run();
	end
endmodule

bind pwct_timer pwct_timer_monitor pwct_timer_monitor_i (
	.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.capture_input_pin_i(capture_input_pin_i), .rdata_o(rdata_o),
	.timer_event_irq_o(timer_event_irq_o));
`default_nettype wire
